//--- rtl/ifd_defines.svh
// Field positions, opcode groups and reset values for the instruction format decoder.
// Function
// - Operand meaning of each field follows the opcode bits.
// - Single-destination format: bits 11-8 destination; source none or control register.
// - Single-source format: bits 11-8 source, direct or post-increment, or jump target.
// - Register-relative branch target is program counter plus named register.
// - Two-register format: bits 11-8 destination, bits 7-4 source, six operand kinds.
// - Multiply-accumulate: bits 7-4 post-increment source, bits 11-8 register, result to mac high/low.
// - Load with displacement: base bits 7-4, displacement bits 3-0, destination register zero.
// - Store with displacement: source register zero, address base bits 7-4 plus displacement.
// - Four-bit displacement zero-extended and scaled one, two or four by size.
// - Eight-bit global-base displacement zero-extended, scaled by size, added to base.
// - Eight- and twelve-bit branch displacements sign-extended, doubled, added to counter.
// - Immediate zero-extended for logic, sign-extended for move/add/compare, trap quadrupled.
`ifndef IFD_DEFINES_SVH
`define IFD_DEFINES_SVH
`define IFD_OP_HI 15
`define IFD_OP_LO 12
`define IFD_N_HI 11
`define IFD_N_LO 8
`define IFD_M_HI 7
`define IFD_M_LO 4
`define IFD_D_HI 3
`define IFD_D_LO 0
`define IFD_D12_HI 11
`define IFD_GRP_SYS 4'h0
`define IFD_GRP_ST_DISP 4'h1
`define IFD_GRP_ST 4'h2
`define IFD_GRP_ARITH 4'h3
`define IFD_GRP_CTL 4'h4
`define IFD_GRP_LD_DISP 4'h5
`define IFD_GRP_LD 4'h6
`define IFD_GRP_ADD_IMM 4'h7
`define IFD_GRP_R0_DISP 4'h8
`define IFD_GRP_PC_W 4'h9
`define IFD_GRP_BRA 4'ha
`define IFD_GRP_BSR 4'hb
`define IFD_GRP_GBR 4'hc
`define IFD_GRP_PC_L 4'hd
`define IFD_GRP_MOV_IMM 4'he
`define IFD_SH_X1 2'h0
`define IFD_SH_X2 2'h1
`define IFD_SH_X4 2'h2
`define IFD_REG_ZERO 4'h0
`define IFD_RST_WORD 32'h0000_0000
`endif

//--- rtl/ifd_pkg.sv
// Types shared by the instruction format decoder files.
package ifd_pkg;
  typedef enum logic [3:0] {IFD_F0, IFD_FN, IFD_FM, IFD_FNM, IFD_FMD, IFD_FND4, IFD_FNMD, IFD_FD,
                            IFD_FD12, IFD_FND8, IFD_FI, IFD_FNI} ifd_fmt_t;
  typedef enum logic [3:0] {IFD_K_NONE, IFD_K_DIRECT, IFD_K_IND, IFD_K_POSTINC, IFD_K_PREDEC,
                            IFD_K_IDX_R, IFD_K_DISP_REG, IFD_K_DISP_GLB, IFD_K_PC_REL, IFD_K_CTL_SYS,
                            IFD_K_MAC_HL, IFD_K_IMM, IFD_K_IDX_GLB} ifd_kind_t;
  typedef enum logic [1:0] {IFD_SZ_B, IFD_SZ_W, IFD_SZ_L} ifd_size_t;
  typedef enum logic [1:0] {IFD_X_ZERO4, IFD_X_ZERO8, IFD_X_SIGN8, IFD_X_SIGN12} ifd_ext_t;
  typedef enum logic [3:0] {IFD_B_NONE, IFD_B_N, IFD_B_M, IFD_B_N_ZR, IFD_B_M_ZR, IFD_B_GLB,
                            IFD_B_GLB_ZR, IFD_B_PC, IFD_B_PC_N} ifd_base_t;
  typedef struct packed {
    logic valid;
    logic [15:0] word;
    logic [31:0] pc;
  } ifd_req_t;
  typedef struct packed {
    logic [31:0] reg_11_8_val;
    logic [31:0] reg_7_4_val;
    logic [31:0] general_reg_zero_val;
    logic [31:0] global_base_reg_val;
  } ifd_regs_t;
  typedef struct packed {
    logic valid;
    ifd_fmt_t fmt;
    ifd_kind_t src_kind;
    ifd_kind_t dst_kind;
    logic [3:0] src_reg;
    logic [3:0] dst_reg;
    ifd_size_t size;
    logic mac_dst;
    logic [31:0] disp_off;
    logic [31:0] imm;
    logic [31:0] addr;
  } ifd_dec_t;
endpackage : ifd_pkg

//--- rtl/ifd_disp_scaler.sv
// Extends a displacement or immediate field and scales it by a power of two.
`timescale 1ns/10ps
`include "ifd_defines.svh"
module ifd_disp_scaler
  import ifd_pkg::*;
(
  input wire logic [11:0] field,
  input wire ifd_ext_t mode,
  input wire logic [1:0] shift,
  output logic [31:0] value
);
  wire [31:0] ext_zero4 = {28'h0, field[`IFD_D_HI:`IFD_D_LO]};
  wire [31:0] ext_zero8 = {24'h0, field[7:0]};
  wire [31:0] ext_sign8 = {{24{field[7]}}, field[7:0]};
  wire [31:0] ext_sign12 = {{20{field[`IFD_D12_HI]}}, field};
  wire [31:0] ext_val = (mode == IFD_X_ZERO4) ? ext_zero4 :
                        (mode == IFD_X_ZERO8) ? ext_zero8 :
                        (mode == IFD_X_SIGN8) ? ext_sign8 : ext_sign12;
  assign value = ext_val << shift;
endmodule : ifd_disp_scaler

//--- rtl/insn_format_operand_decoder.sv
// Registered decoder of 16-bit instruction words into operand fields, kinds and addresses.
`timescale 1ns/10ps
`include "ifd_defines.svh"
module insn_format_operand_decoder
  import ifd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire ifd_req_t req,
  input wire ifd_regs_t regs,
  output ifd_dec_t dec
);
  wire [3:0] grp = req.word[`IFD_OP_HI:`IFD_OP_LO];
  wire [3:0] fld_n = req.word[`IFD_N_HI:`IFD_N_LO];
  wire [3:0] fld_m = req.word[`IFD_M_HI:`IFD_M_LO];
  wire [3:0] fld_lo = req.word[`IFD_D_HI:`IFD_D_LO];

  ifd_fmt_t fmt_c;
  ifd_kind_t sk_c;
  ifd_kind_t dk_c;
  logic [3:0] src_reg_c;
  logic [3:0] dst_reg_c;
  ifd_size_t sz_c;
  logic mac_c;
  ifd_ext_t dmode_c;
  logic [1:0] dsh_c;
  ifd_ext_t imode_c;
  logic [1:0] ish_c;
  ifd_base_t base_c;
  logic predec_c;

  always_comb begin
    fmt_c = IFD_F0;
    sk_c = IFD_K_NONE;
    dk_c = IFD_K_NONE;
    src_reg_c = `IFD_REG_ZERO;
    dst_reg_c = `IFD_REG_ZERO;
    sz_c = IFD_SZ_L;
    mac_c = 1'b0;
    dmode_c = IFD_X_ZERO4;
    dsh_c = `IFD_SH_X1;
    imode_c = IFD_X_ZERO8;
    ish_c = `IFD_SH_X1;
    base_c = IFD_B_NONE;
    predec_c = 1'b0;
    case (grp)
      `IFD_GRP_SYS: begin
        case (fld_lo)
          4'h2, 4'ha: begin
            fmt_c = IFD_FN;
            sk_c = IFD_K_CTL_SYS;
            dk_c = IFD_K_DIRECT;
            dst_reg_c = fld_n;
          end
          4'h3: begin
            fmt_c = IFD_FM;
            sk_c = IFD_K_PC_REL;
            src_reg_c = fld_n;
            base_c = IFD_B_PC_N;
          end
          4'h4, 4'h5, 4'h6: begin
            fmt_c = IFD_FNM;
            sk_c = IFD_K_DIRECT;
            dk_c = IFD_K_IDX_R;
            src_reg_c = fld_m;
            dst_reg_c = fld_n;
            sz_c = ifd_size_t'(fld_lo[1:0]);
            base_c = IFD_B_N_ZR;
          end
          4'h7: begin
            fmt_c = IFD_FNM;
            sk_c = IFD_K_DIRECT;
            dk_c = IFD_K_MAC_HL;
            src_reg_c = fld_m;
            dst_reg_c = fld_n;
            mac_c = 1'b1;
          end
          4'h9: begin
            if (fld_m == 4'h2) begin
              fmt_c = IFD_FN;
              dk_c = IFD_K_DIRECT;
              dst_reg_c = fld_n;
            end
          end
          4'hc, 4'hd, 4'he: begin
            fmt_c = IFD_FNM;
            sk_c = IFD_K_IDX_R;
            dk_c = IFD_K_DIRECT;
            src_reg_c = fld_m;
            dst_reg_c = fld_n;
            sz_c = ifd_size_t'(fld_lo[1:0]);
            base_c = IFD_B_M_ZR;
          end
          4'hf: begin
            fmt_c = IFD_FNM;
            sk_c = IFD_K_POSTINC;
            dk_c = IFD_K_MAC_HL;
            src_reg_c = fld_m;
            dst_reg_c = fld_n;
            mac_c = 1'b1;
            base_c = IFD_B_M;
          end
          default: begin
            fmt_c = IFD_F0;
          end
        endcase
      end
      `IFD_GRP_ST_DISP: begin
        fmt_c = IFD_FNMD;
        sk_c = IFD_K_DIRECT;
        dk_c = IFD_K_DISP_REG;
        src_reg_c = fld_m;
        dst_reg_c = fld_n;
        dsh_c = `IFD_SH_X4;
        base_c = IFD_B_N;
      end
      `IFD_GRP_ST, `IFD_GRP_LD: begin
        fmt_c = IFD_FNM;
        src_reg_c = fld_m;
        dst_reg_c = fld_n;
        sz_c = ifd_size_t'(fld_lo[1:0]);
        sk_c = IFD_K_DIRECT;
        dk_c = IFD_K_DIRECT;
        if (fld_lo[3] == 1'b0 && fld_lo[1:0] != 2'h3) begin
          if (grp == `IFD_GRP_ST) begin
            dk_c = fld_lo[2] ? IFD_K_PREDEC : IFD_K_IND;
            base_c = IFD_B_N;
            predec_c = fld_lo[2];
          end else begin
            sk_c = fld_lo[2] ? IFD_K_POSTINC : IFD_K_IND;
            base_c = IFD_B_M;
          end
        end else begin
          sz_c = IFD_SZ_L;
        end
      end
      `IFD_GRP_ARITH: begin
        fmt_c = IFD_FNM;
        sk_c = IFD_K_DIRECT;
        dk_c = IFD_K_DIRECT;
        src_reg_c = fld_m;
        dst_reg_c = fld_n;
      end
      `IFD_GRP_CTL: begin
        case (fld_lo)
          4'hf: begin
            fmt_c = IFD_FNM;
            sk_c = IFD_K_POSTINC;
            dk_c = IFD_K_MAC_HL;
            src_reg_c = fld_m;
            dst_reg_c = fld_n;
            sz_c = IFD_SZ_W;
            mac_c = 1'b1;
            base_c = IFD_B_M;
          end
          4'h2, 4'h3: begin
            fmt_c = IFD_FN;
            sk_c = IFD_K_CTL_SYS;
            dk_c = IFD_K_PREDEC;
            dst_reg_c = fld_n;
            base_c = IFD_B_N;
            predec_c = 1'b1;
          end
          4'h6, 4'h7, 4'ha, 4'he: begin
            fmt_c = IFD_FM;
            sk_c = fld_lo[3] ? IFD_K_DIRECT : IFD_K_POSTINC;
            dk_c = IFD_K_CTL_SYS;
            src_reg_c = fld_n;
            base_c = fld_lo[3] ? IFD_B_NONE : IFD_B_N;
          end
          4'hb: begin
            if (fld_m == 4'h1) begin
              fmt_c = IFD_FN;
              dk_c = IFD_K_IND;
              dst_reg_c = fld_n;
              sz_c = IFD_SZ_B;
              base_c = IFD_B_N;
            end else begin
              fmt_c = IFD_FM;
              sk_c = IFD_K_DIRECT;
              src_reg_c = fld_n;
              base_c = IFD_B_N;
            end
          end
          default: begin
            fmt_c = IFD_FN;
            dk_c = IFD_K_DIRECT;
            dst_reg_c = fld_n;
          end
        endcase
      end
      `IFD_GRP_LD_DISP: begin
        fmt_c = IFD_FNMD;
        sk_c = IFD_K_DISP_REG;
        dk_c = IFD_K_DIRECT;
        src_reg_c = fld_m;
        dst_reg_c = fld_n;
        dsh_c = `IFD_SH_X4;
        base_c = IFD_B_M;
      end
      `IFD_GRP_ADD_IMM, `IFD_GRP_MOV_IMM: begin
        fmt_c = IFD_FNI;
        sk_c = IFD_K_IMM;
        dk_c = IFD_K_DIRECT;
        dst_reg_c = fld_n;
        imode_c = IFD_X_SIGN8;
      end
      `IFD_GRP_R0_DISP: begin
        sz_c = ifd_size_t'(fld_n[1:0]);
        dsh_c = fld_n[1:0];
        case (fld_n)
          4'h0, 4'h1: begin
            fmt_c = IFD_FND4;
            sk_c = IFD_K_DIRECT;
            dk_c = IFD_K_DISP_REG;
            dst_reg_c = fld_m;
            base_c = IFD_B_M;
          end
          4'h4, 4'h5: begin
            fmt_c = IFD_FMD;
            sk_c = IFD_K_DISP_REG;
            dk_c = IFD_K_DIRECT;
            src_reg_c = fld_m;
            base_c = IFD_B_M;
          end
          4'h8: begin
            fmt_c = IFD_FI;
            sk_c = IFD_K_IMM;
            dk_c = IFD_K_DIRECT;
            imode_c = IFD_X_SIGN8;
          end
          4'h9, 4'hb, 4'hd, 4'hf: begin
            fmt_c = IFD_FD;
            sk_c = IFD_K_PC_REL;
            dmode_c = IFD_X_SIGN8;
            dsh_c = `IFD_SH_X2;
            base_c = IFD_B_PC;
          end
          default: begin
            fmt_c = IFD_F0;
          end
        endcase
      end
      `IFD_GRP_PC_W, `IFD_GRP_PC_L: begin
        fmt_c = IFD_FND8;
        sk_c = IFD_K_PC_REL;
        dk_c = IFD_K_DIRECT;
        dst_reg_c = fld_n;
        sz_c = grp[2] ? IFD_SZ_L : IFD_SZ_W;
        dmode_c = IFD_X_ZERO8;
        dsh_c = grp[2] ? `IFD_SH_X4 : `IFD_SH_X2;
        base_c = IFD_B_PC;
      end
      `IFD_GRP_BRA, `IFD_GRP_BSR: begin
        fmt_c = IFD_FD12;
        sk_c = IFD_K_PC_REL;
        dmode_c = IFD_X_SIGN12;
        dsh_c = `IFD_SH_X2;
        base_c = IFD_B_PC;
      end
      `IFD_GRP_GBR: begin
        sz_c = ifd_size_t'(fld_n[1:0]);
        dmode_c = IFD_X_ZERO8;
        dsh_c = fld_n[1:0];
        if (fld_n[3:2] == 2'h0 && fld_n[1:0] != 2'h3) begin
          fmt_c = IFD_FD;
          sk_c = IFD_K_DIRECT;
          dk_c = IFD_K_DISP_GLB;
          base_c = IFD_B_GLB;
        end else if (fld_n == 4'h3) begin
          fmt_c = IFD_FI;
          sk_c = IFD_K_IMM;
          ish_c = `IFD_SH_X4;
        end else if (fld_n[3:2] == 2'h1 && fld_n[1:0] != 2'h3) begin
          fmt_c = IFD_FD;
          sk_c = IFD_K_DISP_GLB;
          dk_c = IFD_K_DIRECT;
          base_c = IFD_B_GLB;
        end else if (fld_n == 4'h7) begin
          fmt_c = IFD_FD;
          sk_c = IFD_K_PC_REL;
          dk_c = IFD_K_DIRECT;
          dsh_c = `IFD_SH_X4;
          base_c = IFD_B_PC;
        end else begin
          fmt_c = IFD_FI;
          sk_c = IFD_K_IMM;
          dk_c = fld_n[2] ? IFD_K_IDX_GLB : IFD_K_DIRECT;
          sz_c = fld_n[2] ? IFD_SZ_B : IFD_SZ_L;
          base_c = fld_n[2] ? IFD_B_GLB_ZR : IFD_B_NONE;
        end
      end
      default: begin
        fmt_c = IFD_F0;
      end
    endcase
  end

  wire [31:0] disp_off_c;
  wire [31:0] imm_c;

  ifd_disp_scaler u_disp (
    .field(req.word[`IFD_D12_HI:0]),
    .mode(dmode_c),
    .shift(dsh_c),
    .value(disp_off_c)
  );

  ifd_disp_scaler u_imm (
    .field(req.word[`IFD_D12_HI:0]),
    .mode(imode_c),
    .shift(ish_c),
    .value(imm_c)
  );

  // A pre-decrement address is taken after the subtraction, so the size step is folded in here.
  wire [31:0] size_step = (sz_c == IFD_SZ_B) ? 32'h0000_0001 :
                          (sz_c == IFD_SZ_W) ? 32'h0000_0002 : 32'h0000_0004;
  wire [31:0] base_val = (base_c == IFD_B_N || base_c == IFD_B_N_ZR || base_c == IFD_B_PC_N) ?
                         regs.reg_11_8_val :
                         (base_c == IFD_B_M || base_c == IFD_B_M_ZR) ? regs.reg_7_4_val :
                         (base_c == IFD_B_GLB || base_c == IFD_B_GLB_ZR) ? regs.global_base_reg_val :
                         (base_c == IFD_B_PC) ? req.pc : `IFD_RST_WORD;
  wire use_zr = (base_c == IFD_B_N_ZR || base_c == IFD_B_M_ZR || base_c == IFD_B_GLB_ZR);
  wire use_pc = (base_c == IFD_B_PC_N);
  wire use_disp = (sk_c == IFD_K_DISP_REG || dk_c == IFD_K_DISP_REG || sk_c == IFD_K_DISP_GLB ||
                   dk_c == IFD_K_DISP_GLB || sk_c == IFD_K_PC_REL) && !use_pc;
  wire [31:0] add_a = use_zr ? regs.general_reg_zero_val : use_pc ? req.pc :
                      use_disp ? disp_off_c : `IFD_RST_WORD;
  wire [31:0] sum_c = base_val + add_a;
  wire [31:0] addr_c = predec_c ? (base_val - size_step) : sum_c;

  ifd_dec_t dec_nxt;
  assign dec_nxt = '{valid: req.valid, fmt: fmt_c, src_kind: sk_c, dst_kind: dk_c,
                     src_reg: src_reg_c, dst_reg: dst_reg_c, size: sz_c, mac_dst: mac_c,
                     disp_off: disp_off_c, imm: imm_c, addr: addr_c};

  ifd_dec_t dec_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dec_r <= '0;
    end else begin
      dec_r <= dec_nxt;
    end
  end
  assign dec = dec_r;
endmodule : insn_format_operand_decoder

//--- verif/ifd_checker_asserts.sv
// Concurrent checks of the decoder outputs against the inputs taken one edge earlier.
`timescale 1ns/10ps
module ifd_checker
  import ifd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire ifd_req_t req,
  input wire ifd_regs_t regs,
  input wire ifd_dec_t dec
);
  logic live_r;
  ifd_req_t req_r;
  ifd_regs_t regs_r;
  wire [3:0] grp = req_r.word[15:12];
  wire [3:0] fld_n = req_r.word[11:8];
  wire [3:0] fld_lo = req_r.word[3:0];
  wire [31:0] sext8 = {{24{req_r.word[7]}}, req_r.word[7:0]};
  wire [31:0] sext12x2 = {{19{req_r.word[11]}}, req_r.word[11:0], 1'b0};
  wire [31:0] lo_x4 = {26'h0, fld_lo, 2'h0};

  // Shadow copies of the inputs; live_r masks the first edge after reset, when dec still holds reset values.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      live_r <= 1'b0;
      req_r <= '0;
      regs_r <= '0;
    end else begin
      live_r <= 1'b1;
      req_r <= req;
      regs_r <= regs;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_grp(logic [3:0] g);
    live_r && grp == g;
  endsequence

  a_valid_follow: assert property (req.valid |=> dec.valid)
    else $error("decoded word not marked valid after a valid request");
  a_imm_sign: assert property (s_grp(4'h7) |-> dec.imm == sext8 && dec.dst_reg == fld_n)
    else $error("add immediate not sign extended or wrong register");
  a_branch_long: assert property ((live_r && grp[3:1] == 3'h5) |-> dec.addr == req_r.pc + sext12x2)
    else $error("long branch target wrong");
  a_store_disp: assert property (s_grp(4'h1) |->
    dec.addr == regs_r.reg_11_8_val + lo_x4 && dec.disp_off == lo_x4)
    else $error("store displacement address wrong");
  a_load_disp: assert property (s_grp(4'h5) |->
    dec.addr == regs_r.reg_7_4_val + lo_x4 && dec.dst_reg == fld_n)
    else $error("load displacement address wrong");
  a_mac_result: assert property ((live_r && fld_lo == 4'hf && (grp == 4'h0 || grp == 4'h4)) |->
    dec.mac_dst && dec.dst_kind == IFD_K_MAC_HL && dec.src_kind == IFD_K_POSTINC)
    else $error("multiply accumulate operands wrong");
  a_reg_branch: assert property ((live_r && grp == 4'h0 && fld_lo == 4'h3) |->
    dec.addr == req_r.pc + regs_r.reg_11_8_val && dec.src_reg == fld_n)
    else $error("register relative branch target wrong");
  a_zero_load: assert property ((live_r && req_r.word[15:8] == 8'h84) |->
    dec.dst_reg == 4'h0 && dec.addr == regs_r.reg_7_4_val + {28'h0, fld_lo})
    else $error("byte load to register zero wrong");
endmodule : ifd_checker

bind insn_format_operand_decoder ifd_checker i_chk (.core_clk(core_clk), .rst_n(rst_n), .req(req), .regs(regs),
  .dec(dec));

//--- verif/ifd_fetch_model.sv
// Register file side model that supplies operand register values for the word being decoded.
`timescale 1ns/10ps
module ifd_fetch_model
  import ifd_pkg::*;
(
  input wire ifd_req_t req,
  output ifd_regs_t regs
);
  logic [31:0] gpr [16];
  logic [31:0] global_base_reg;
  logic [31:0] flip;
  // Without a valid word the read port shows inverted values, so stale data is never mistaken for good.
  assign flip = req.valid ? 32'h0000_0000 : 32'hffff_ffff;
  assign regs = {gpr[req.word[11:8]] ^ flip, gpr[req.word[7:4]] ^ flip, gpr[0] ^ flip, global_base_reg ^ flip};
endmodule : ifd_fetch_model

//--- verif/tb_top.sv
// Self-checking bench: random instruction words against a behavioural decode model.
`timescale 1ns/10ps
module tb_top
  import ifd_pkg::*;
;
  typedef struct packed {
    logic [8:0] chk;
    logic vld;
    ifd_fmt_t fmt;
    ifd_kind_t sk;
    ifd_kind_t dk;
    logic [3:0] sr;
    logic [3:0] dr;
    logic mac;
    logic [31:0] disp;
    logic [31:0] imm;
    logic [31:0] addr;
    logic [1:0] sz;
  } ifd_exp_t;
  logic core_clk;
  logic rst_n;
  ifd_req_t req;
  ifd_regs_t regs;
  ifd_dec_t dec;
  int bad_count;
  int n_checks;
  int seed;
  int gpr [16];
  int global_base_reg;
  ifd_exp_t exp_q [$];
  ifd_exp_t pend;
  logic pend_ok;
  logic [31:0] pat [31];

  insn_format_operand_decoder i_dut (.core_clk(core_clk), .rst_n(rst_n), .req(req), .regs(regs), .dec(dec));
  ifd_fetch_model i_rf (.req(req), .regs(regs));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  function automatic ifd_exp_t mk(logic [8:0] chk, ifd_fmt_t f, ifd_kind_t sk, ifd_kind_t dk, int sr, int dr,
                                  int disp, int imm, int addr);
    mk = '{chk, 1'b1, f, sk, dk, 4'(sr), 4'(dr), dk == IFD_K_MAC_HL, 32'(disp), 32'(imm), 32'(addr), 2'h3};
  endfunction : mk

  // Mask bits select fmt, src kind, dst kind, src reg, dst reg, mac, displacement, immediate, address.
  function automatic ifd_exp_t model(logic [15:0] w, int pc);
    int n;
    int m;
    int lo;
    int z8;
    int s8;
    int s12;
    n = w[11:8];
    m = w[7:4];
    lo = w[3:0];
    z8 = w[7:0];
    s8 = $signed(w[7:0]);
    s12 = $signed(w[11:0]);
    case (w[15:12])
      4'h0: if (lo == 3) model = mk(9'h10b, IFD_FM, IFD_K_PC_REL, IFD_K_NONE, n, 0, 0, 0, pc + gpr[n]);
      else if (lo == 15) model = mk(9'h026, IFD_F0, IFD_K_POSTINC, IFD_K_MAC_HL, 0, 0, 0, 0, 0);
      else if (lo == 12) model = mk(9'h11f, IFD_FNM, IFD_K_IDX_R, IFD_K_DIRECT, m, n, 0, 0, gpr[m] + gpr[0]);
      else model = mk(9'h11f, IFD_FNM, IFD_K_DIRECT, IFD_K_IDX_R, m, n, 0, 0, gpr[n] + gpr[0]);
      4'h1: model = mk(9'h15f, IFD_FNMD, IFD_K_DIRECT, IFD_K_DISP_REG, m, n, lo * 4, 0, gpr[n] + lo * 4);
      4'h5: model = mk(9'h15f, IFD_FNMD, IFD_K_DISP_REG, IFD_K_DIRECT, m, n, lo * 4, 0, gpr[m] + lo * 4);
      4'h2: model = mk(9'h11e, IFD_F0, IFD_K_DIRECT, IFD_K_PREDEC, m, n, 0, 0, gpr[n] - 4);
      4'h6: model = mk(9'h11e, IFD_F0, IFD_K_POSTINC, IFD_K_DIRECT, m, n, 0, 0, gpr[m]);
      4'h3: model = mk(9'h11f, IFD_FNM, IFD_K_DIRECT, IFD_K_DIRECT, m, n, 0, 0, 0);
      4'h4: if (lo == 15) model = mk(9'h026, IFD_F0, IFD_K_POSTINC, IFD_K_MAC_HL, 0, 0, 0, 0, 0);
      else if (lo == 6) model = mk(9'h00f, IFD_FM, IFD_K_POSTINC, IFD_K_CTL_SYS, n, 0, 0, 0, 0);
      else if (lo == 11) model = mk(9'h10f, IFD_FM, IFD_K_DIRECT, IFD_K_NONE, n, 0, 0, 0, gpr[n]);
      else model = mk(9'h117, IFD_FN, IFD_K_CTL_SYS, IFD_K_PREDEC, 0, n, 0, 0, gpr[n] - 4);
      4'h7, 4'he: model = mk(9'h097, IFD_FNI, IFD_K_IMM, IFD_K_DIRECT, 0, n, 0, s8, 0);
      4'h8: if (n < 2) model = mk(9'h15f, IFD_FND4, IFD_K_DIRECT, IFD_K_DISP_REG, 0, m, lo << n, 0,
                                  gpr[m] + (lo << n));
      else if (n < 6) model = mk(9'h15f, IFD_FMD, IFD_K_DISP_REG, IFD_K_DIRECT, m, 0, lo << (n - 4), 0,
                                 gpr[m] + (lo << (n - 4)));
      else if (n == 8) model = mk(9'h081, IFD_FI, IFD_K_NONE, IFD_K_NONE, 0, 0, 0, s8, 0);
      else model = mk(9'h141, IFD_FD, IFD_K_NONE, IFD_K_NONE, 0, 0, s8 * 2, 0, pc + s8 * 2);
      4'h9: model = mk(9'h153, IFD_FND8, IFD_K_PC_REL, IFD_K_NONE, 0, n, z8 * 2, 0, pc + z8 * 2);
      4'hd: model = mk(9'h153, IFD_FND8, IFD_K_PC_REL, IFD_K_NONE, 0, n, z8 * 4, 0, pc + z8 * 4);
      4'ha, 4'hb: model = mk(9'h141, IFD_FD12, IFD_K_NONE, IFD_K_NONE, 0, 0, s12 * 2, 0, pc + s12 * 2);
      4'hc: if (n < 3) model = mk(9'h145, IFD_FD, IFD_K_NONE, IFD_K_DISP_GLB, 0, 0, z8 << n, 0, global_base_reg + (z8 << n));
      else if (n == 3) model = mk(9'h081, IFD_FI, IFD_K_NONE, IFD_K_NONE, 0, 0, 0, z8 * 4, 0);
      else if (n < 7) model = mk(9'h143, IFD_FD, IFD_K_DISP_GLB, IFD_K_NONE, 0, 0, z8 << (n - 4), 0,
                                 global_base_reg + (z8 << (n - 4)));
      else if (n < 12) model = mk(9'h081, IFD_FI, IFD_K_NONE, IFD_K_NONE, 0, 0, 0, z8, 0);
      else model = mk(9'h185, IFD_FI, IFD_K_NONE, IFD_K_IDX_GLB, 0, 0, 0, z8, global_base_reg + gpr[0]);
      default: model = mk(9'h007, IFD_F0, IFD_K_NONE, IFD_K_NONE, 0, 0, 0, 0, 0);
    endcase
    // A size of 3 marks a word whose access size carries no meaning here.
    model.sz = 2'h3;
    if ((w[15:12] == 4'h8 && n < 6) || (w[15:12] == 4'hc && n < 7 && n != 3)) model.sz = 2'(n % 4);
    else if (w[15:12] == 4'h9 || (w[15:12] == 4'h4 && lo == 15)) model.sz = IFD_SZ_W;
    else if ((w[15:12] == 4'h0 && (lo == 4 || lo == 12)) || (w[15:12] == 4'hc && n > 11)) model.sz = IFD_SZ_B;
    else if (w[15:12] inside {4'h1, 4'h2, 4'h5, 4'h6, 4'hd} || (w[15:12] == 4'h0 && lo == 6)) model.sz = IFD_SZ_L;
  endfunction : model

  task automatic cmp(logic [31:0] got, logic [31:0] want);
    n_checks++;
    if (got !== want) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, want);
    end
  endtask : cmp

  task automatic check(ifd_exp_t e);
    cmp({31'h0, dec.valid}, {31'h0, e.vld});
    if (e.chk[0]) cmp({28'h0, dec.fmt}, {28'h0, e.fmt});
    if (e.chk[1]) cmp({28'h0, dec.src_kind}, {28'h0, e.sk});
    if (e.chk[2]) cmp({28'h0, dec.dst_kind}, {28'h0, e.dk});
    if (e.chk[3]) cmp({28'h0, dec.src_reg}, {28'h0, e.sr});
    if (e.chk[4]) cmp({28'h0, dec.dst_reg}, {28'h0, e.dr});
    if (e.chk[5]) cmp({31'h0, dec.mac_dst}, {31'h0, e.mac});
    if (e.chk[6]) cmp(dec.disp_off, e.disp);
    if (e.chk[7]) cmp(dec.imm, e.imm);
    if (e.chk[8]) cmp(dec.addr, e.addr);
    if (e.vld && e.sz != 2'h3) cmp({30'h0, dec.size}, {30'h0, e.sz});
  endtask : check

  task automatic drive(logic v, logic [15:0] w, int pc);
    @(posedge core_clk);
    req <= '{v, w, 32'(pc)};
    if (v) pend = model(w, pc);
    else pend = '0;
    pend_ok = 1'b1;
  endtask : drive

  // Expectations queue one edge behind the drive, matching the single cycle of latency.
  always @(posedge core_clk) begin
    #1;
    if (!rst_n) begin
      exp_q.delete();
    end else begin
      if (exp_q.size() > 0) check(exp_q.pop_front());
      if (pend_ok) exp_q.push_back(pend);
    end
    pend_ok = 1'b0;
  end

  task automatic finish_test();
    if (bad_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    #(3000 * 100);
    bad_count++;
    finish_test();
  end

  initial begin
    int k;
    int idx;
    logic [31:0] p;
    seed = 53;
    pat = '{32'h0f00_0023, 32'h0ff0_000f, 32'h0ff0_0004, 32'h0ff0_0006, 32'h0fff_1000, 32'h0ff0_2006,
            32'h0ff0_6006, 32'h0ff0_400f, 32'h0ff0_4006, 32'h0ff0_4002, 32'h0fff_5000, 32'h0fff_7000,
            32'h0fff_e000, 32'h01ff_8000, 32'h01ff_8400, 32'h00ff_8800, 32'h06ff_8900, 32'h0fff_9000,
            32'h0fff_d000, 32'h1fff_a000, 32'h01ff_c000, 32'h00ff_c200, 32'h00ff_c300, 32'h01ff_c400,
            32'h00ff_c600, 32'h03ff_c800, 32'h0fff_f000, 32'h0ff0_000c, 32'h0fff_3000, 32'h0f00_400b,
            32'h03ff_cc00};
    for (k = 0; k < 16; k++) gpr[k] = $random(seed);
    global_base_reg = $random(seed);
    for (k = 0; k < 16; k++) i_rf.gpr[k] = gpr[k];
    i_rf.global_base_reg = global_base_reg;
    rst_n = 1'b0;
    req = '0;
    pend_ok = 1'b0;
    bad_count = 0;
    n_checks = 0;
    repeat (6) @(posedge core_clk);
    #1 cmp({31'h0, dec === '0}, 32'h1);
    #20 rst_n = 1'b1;
    for (k = 0; k < 800; k++) begin
      if (k == 400) begin
        #30 rst_n = 1'b0;
        #1 cmp({31'h0, dec === '0}, 32'h1);
        repeat (2) @(posedge core_clk);
        #20 rst_n = 1'b1;
      end
      idx = {$random(seed)} % 31;
      p = pat[idx];
      drive(k % 9 != 8, p[15:0] | (p[31:16] & 16'($random(seed))), $random(seed));
    end
    repeat (3) @(posedge core_clk);
    #2;
    finish_test();
  end
endmodule : tb_top
